// ---- testbench.sv ----
// Self-checking bench of the fault response block with a link host model.
// Assumes the package, the block, the checker and the host model come first.
`timescale 1ns/1ps

module testbench;
  import uvo_pkg::*;

  // ********
  // Signals
  // ********
  logic        sys_clk;
  logic        sys_rst;
  logic        link_clk;
  logic        cmd_valid;
  logic        cmd_busy;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic [2:0]  det;
  logic        on_cmd;
  logic        ramping;
  logic        mask;
  logic        nvm_store;
  logic        power_en;
  logic        alert_n;
  logic [16:0] note;
  logic [31:0] rnd;
  uvo_req_s    req;
  uvo_nvm_s    nvm_rd;
  uvo_nvm_s    nvm_wd;
  uvo_status_s status;
  logic [16:0] rsp_q[$];
  uvo_nvm_s    nvm_q[$];
  int          error_cnt;
  int          checks;
  localparam uvo_status_s ST_COMM = '{comm_fault_flag:1, invalid_data_flag:1, default:0};
  localparam uvo_status_s ST_OC = '{overcurrent_fault_byte:1, current_summary_flag:1,
                                    overcurrent_fault_flag:1, default:0};
  localparam uvo_status_s ST_OCW = '{other_fault_flag:1, current_summary_flag:1,
                                     overcurrent_warning_flag:1, default:0};
  localparam uvo_status_s ST_UV = '{other_fault_flag:1, voltage_summary_flag:1,
                                    undervoltage_fault_flag:1, default:0};

  // Unrelated clocks: 5 ns system, 15 ns link
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  // Short rise time keeps the seven-rise restart wait at 28 cycles
  uvo_fault_resp #(.HI_CURRENT(1'b1), .RISE_CYCLES(4)) dut (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .link_clk_i(link_clk),
    .cmd_valid_i(cmd_valid), .cmd_req_i(req), .cmd_busy_o(cmd_busy),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .uv_detect_i(det[2]),
    .oc_detect_i(det[1]), .ocw_detect_i(det[0]), .on_cmd_i(on_cmd), .ramping_i(ramping),
    .alert_mask_i(mask), .nvm_rdata_i(nvm_rd), .nvm_store_o(nvm_store),
    .nvm_wdata_o(nvm_wd), .power_en_o(power_en), .status_o(status), .smbalert_n_o(alert_n)
  );
  uvo_host_model host (
    .link_clk_i(link_clk), .cmd_busy_i(cmd_busy), .rsp_valid_i(rsp_valid),
    .cmd_valid_o(cmd_valid), .cmd_req_o(req)
  );

  // ********
  // Tasks
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_w

  task automatic chk_s(input logic [10:0] g, input logic [10:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_s

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // Note the expected answer (bit 16 set when it matters), then send
  task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] d,
                    input logic [16:0] e);
    rsp_q.push_back(e);
    host.xfer(w, c, d);
  endtask : rw

  // Alert expected low exactly when flags stand, mask off
  task automatic st(input uvo_status_s s, input logic p);
    cyc(6);
    chk_s({alert_n, power_en, status}, {~|s, p, s});
  endtask : st

  task automatic clr();
    rw(1'b1, 8'h03, 16'h0000, 17'h0);
    st('0, 1'b1);
  endtask : clr

  task automatic fault(input logic [2:0] v);
    @(posedge sys_clk) det <= v;
    cyc(4);
    det <= 3'h0;
  endtask : fault

  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ********
  // Monitors
  // ********
  always @(posedge link_clk) begin
    if (rsp_valid === 1'b1) begin
      note = (rsp_q.size() > 0) ? rsp_q.pop_front() : 17'h1FFFF;
      if (note[16]) begin
        chk_w(rsp_data, note[15:0]);
      end
    end
  end
  always @(posedge sys_clk) begin
    if (nvm_store === 1'b1) begin
      chk_s(nvm_wd, nvm_q.pop_front());
    end
  end

  // Watchdog: the whole sequence needs well under 100 us
  initial begin
    #300000;
    error_cnt++;
    stop_test();
  end

  // ********
  // Sequence
  // ********
  initial begin
    sys_rst = 1'b1;
    det = 3'h0;
    on_cmd = 1'b1;
    ramping = 1'b0;
    mask = 1'b0;
    nvm_rd = '0;
    rnd = 32'h64FD;
    cyc(16);
    sys_rst <= 1'b0;
    repeat (10) @(posedge link_clk);
    rw(1'b0, 8'h45, 16'h0000, 17'h100BF);
    rw(1'b0, 8'h47, 16'h0000, 17'h100BF);
    rw(1'b0, 8'h46, 16'h0000, 17'h1F848);
    rw(1'b0, 8'h4A, 16'h0000, 17'h1F844);
    st('0, 1'b1);
    // Every mixed retry code is refused and leaves the old image
    for (int i = 1; i < 7; i++) begin
      rw(1'b1, 8'h47, {8'h00, 2'b10, 3'(i), 3'h7}, 17'h100BF);
      rw(1'b0, 8'h47, 16'h0000, 17'h100BF);
    end
    st(ST_COMM, 1'b1);
    clr();
    rw(1'b1, 8'h46, 16'hF843, 17'h1F848);
    rw(1'b1, 8'h46, 16'hF851, 17'h1F848);
    rw(1'b1, 8'h4A, 16'hF849, 17'h1F844);
    st(ST_COMM, 1'b1);
    clr();
    rw(1'b1, 8'h46, 16'hF844, 17'h0);
    rw(1'b0, 8'h46, 16'h0000, 17'h1F844);
    rw(1'b1, 8'h46, 16'hF848, 17'h0);
    // Random alarm values kept at or below the trip limit
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      rw(1'b1, 8'h4A, {rnd[15:7], 7'(rnd[6:0] % 73)}, 17'h0);
      rw(1'b0, 8'h4A, 16'h0000, {1'b1, 5'h1F, 4'h0, 7'(rnd[6:0] % 73)});
    end
    rw(1'b1, 8'h47, 16'h0000, 17'h0);
    rw(1'b0, 8'h47, 16'h0000, 17'h10007);
    fault(3'b010);
    st(ST_OC, 1'b1);
    clr();
    rw(1'b1, 8'h47, 16'h0080, 17'h0);
    fault(3'b010);
    cyc(40);
    st(ST_OC, 1'b0);
    clr();
    rw(1'b1, 8'h47, 16'h00BF, 17'h0);
    fault(3'b010);
    st(ST_OC, 1'b0);
    cyc(16);
    chk_s({10'h0, power_en}, 11'h0);
    cyc(12);
    chk_s({10'h0, power_en}, 11'h1);
    clr();
    mask <= 1'b1;
    fault(3'b001);
    cyc(6);
    chk_s({alert_n, power_en, status}, {2'b11, ST_OCW});
    clr();
    mask <= 1'b0;
    fault(3'b001);
    st(ST_OCW, 1'b1);
    clr();
    @(posedge sys_clk) ramping <= 1'b1;
    fault(3'b100);
    st('0, 1'b1);
    ramping <= 1'b0;
    fault(3'b100);
    st(ST_UV, 1'b0);
    cyc(30);
    clr();
    rw(1'b1, 8'h45, 16'h0000, 17'h0);
    fault(3'b100);
    st(ST_UV, 1'b0);
    cyc(30);
    clr();
    // Commanded off drops the stage, commanded on brings it back
    on_cmd <= 1'b0;
    cyc(3);
    chk_s({10'h0, power_en}, 11'h0);
    on_cmd <= 1'b1;
    cyc(3);
    chk_s({10'h0, power_en}, 11'h1);
    nvm_q.push_back('{1'b0, 1'b0, 1'b1, 1'b1, 7'h48});
    rw(1'b1, 8'h11, 16'h0000, 17'h0);
    @(posedge sys_clk) nvm_rd <= '{1'b1, 1'b0, 1'b0, 1'b1, 7'h20};
    rw(1'b1, 8'h12, 16'h0000, 17'h0);
    rw(1'b0, 8'h45, 16'h0000, 17'h10087);
    rw(1'b0, 8'h47, 16'h0000, 17'h1003F);
    rw(1'b0, 8'h46, 16'h0000, 17'h1F820);
    rw(1'b0, 8'h4A, 16'h0000, 17'h1F81C);
    repeat (4) @(posedge link_clk);
    chk_w(16'(rsp_q.size() + nvm_q.size()), 16'h0000);
    stop_test();
  end
endmodule : testbench

// ---- uvo_fault_resp.sv ----
// Fault response block: reaction registers, overcurrent limits, status.
// Assumes a command decoder on the link clock and analog comparators
// whose outputs are asynchronous to sys_clk_i.
`timescale 1ns/1ps
`include "uvo_params.svh"

module uvo_fault_resp
  import uvo_pkg::*;
#(
  parameter bit HI_CURRENT  = 1'b1,
  parameter int RISE_CYCLES = `UVO_RISE_TIME_US * `UVO_CLK_MHZ
) (
  // System clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  // Link side, on its own clock
  input  wire logic              link_clk_i,
  input  wire logic              cmd_valid_i,
  input  wire uvo_req_s          cmd_req_i,
  output logic                   cmd_busy_o,
  output logic                   rsp_valid_o,
  output logic [15:0]            rsp_data_o,
  // Asynchronous comparator inputs
  input  wire logic              uv_detect_i,
  input  wire logic              oc_detect_i,
  input  wire logic              ocw_detect_i,
  // Sequencer state on sys_clk_i
  input  wire logic              on_cmd_i,
  input  wire logic              ramping_i,
  input  wire logic              alert_mask_i,
  // Nonvolatile memory engine on sys_clk_i
  input  wire uvo_nvm_s          nvm_rdata_i,
  output logic                   nvm_store_o,
  output uvo_nvm_s               nvm_wdata_o,
  // Results
  output logic                   power_en_o,
  output uvo_status_s            status_o,
  output logic                   smbalert_n_o
);

  // ****************************************************************
  // Constants and helpers
  // ****************************************************************
  localparam logic [6:0] OC_MIN = HI_CURRENT ? `UVO_OC_MIN_HI : `UVO_OC_MIN_LO;
  localparam logic [6:0] OC_MAX = HI_CURRENT ? `UVO_OC_MAX_HI : `UVO_OC_MAX_LO;
  localparam logic [6:0] OC_DEF = HI_CURRENT ? `UVO_OC_DEF_HI : `UVO_OC_DEF_LO;
  localparam logic [31:0] HOLD_LAST = 32'(`UVO_RETRY_RISES * RISE_CYCLES - 1);
  // Reset image of a reaction register, so single fields can be picked out
  localparam logic [7:0]  REACT_RST = `UVO_REACT_RESET;

  // Retry field must be all zeros or all ones
  function automatic logic retry_ok(input logic [15:0] d);
    logic [2:0] f;
    f = d[`UVO_RETRY_HI:`UVO_RETRY_LO];
    retry_ok = (f == 3'h0) || (f == 3'h7);
  endfunction : retry_ok

  // Reaction register read image
  function automatic logic [15:0] react_rd(input logic sd, input logic rb);
    react_rd = {8'h00, sd, 1'b0, {3{rb}}, `UVO_DELAY_CODE};
  endfunction : react_rd

  // Limit word read image
  function automatic logic [15:0] limit_rd(input logic [6:0] m);
    limit_rd = {`UVO_LIMIT_EXP, 4'h0, m};
  endfunction : limit_rd

  // ****************************************************************
  // Link domain: request capture and answer
  // ****************************************************************
  logic       lrst_m_r, lrst_r;
  uvo_req_s   lreq_r;
  logic       lreq_tog_r;
  logic [2:0] lack_sync_r;
  logic       lbusy_r;
  logic       lrsp_valid_r;
  logic [15:0] lrsp_data_r;
  logic       sack_tog_r;
  logic [15:0] srd_data_r;

  // Reset brought into the link domain
  always_ff @(posedge link_clk_i) begin
    lrst_m_r <= sys_rst_i;
    lrst_r   <= lrst_m_r;
  end

  // Request held stable until the system side acknowledges
  always_ff @(posedge link_clk_i) begin
    if (lrst_r) begin
      lreq_r     <= '0;
      lreq_tog_r <= 1'b0;
      lbusy_r    <= 1'b0;
    end else if (cmd_valid_i && !lbusy_r) begin
      lreq_r     <= cmd_req_i;
      lreq_tog_r <= ~lreq_tog_r;
      lbusy_r    <= 1'b1;
    end else if (lack_sync_r[2] != lack_sync_r[1]) begin
      lbusy_r    <= 1'b0;
    end
  end

  // Acknowledge toggle crossing and answer pulse
  always_ff @(posedge link_clk_i) begin
    if (lrst_r) begin
      lack_sync_r  <= 3'h0;
      lrsp_valid_r <= 1'b0;
      lrsp_data_r  <= 16'h0000;
    end else begin
      lack_sync_r  <= {lack_sync_r[1:0], sack_tog_r};
      lrsp_valid_r <= lack_sync_r[2] != lack_sync_r[1];
      if (lack_sync_r[2] != lack_sync_r[1]) begin
        lrsp_data_r <= srd_data_r;  // Stable since it settled before the toggle
      end
    end
  end

  assign cmd_busy_o  = lbusy_r;
  assign rsp_valid_o = lrsp_valid_r;
  assign rsp_data_o  = lrsp_data_r;

  // ****************************************************************
  // System domain: synchronisers
  // ****************************************************************
  logic [2:0] sreq_sync_r;
  logic [1:0] uv_sync_r, oc_sync_r, ocw_sync_r;
  logic       sreq_go;

  // Two flops on each comparator input, three on the request toggle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sreq_sync_r <= 3'h0;
      uv_sync_r   <= 2'h0;
      oc_sync_r   <= 2'h0;
      ocw_sync_r  <= 2'h0;
    end else begin
      sreq_sync_r <= {sreq_sync_r[1:0], lreq_tog_r};
      uv_sync_r   <= {uv_sync_r[0], uv_detect_i};
      oc_sync_r   <= {oc_sync_r[0], oc_detect_i};
      ocw_sync_r  <= {ocw_sync_r[0], ocw_detect_i};
    end
  end

  assign sreq_go = sreq_sync_r[2] != sreq_sync_r[1];

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic       wr_uv, wr_oc, wr_trip, wr_alarm;
  logic       do_clear, do_store, do_restore;
  logic       bad_uv, bad_oc, bad_trip, bad_alarm, cmd_invalid;
  logic [6:0] wmant;
  logic       uv_sd_r, uv_rb_r, oc_sd_r, oc_rb_r;
  logic [6:0] trip_r, alarm_r;

  // Decoding of the synchronised request
  always_comb begin
    wmant      = lreq_r.data[6:0];
    wr_uv      = sreq_go && lreq_r.write && (lreq_r.code == `UVO_CMD_UV_REACT);
    wr_oc      = sreq_go && lreq_r.write && (lreq_r.code == `UVO_CMD_OC_REACT);
    wr_trip    = sreq_go && lreq_r.write && (lreq_r.code == `UVO_CMD_OC_TRIP);
    wr_alarm   = sreq_go && lreq_r.write && (lreq_r.code == `UVO_CMD_OC_ALARM);
    do_clear   = sreq_go && lreq_r.write && (lreq_r.code == `UVO_CMD_CLEAR_FAULTS);
    do_store   = sreq_go && lreq_r.write && (lreq_r.code == `UVO_CMD_STORE_ALL);
    do_restore = sreq_go && lreq_r.write && (lreq_r.code == `UVO_CMD_RESTORE_ALL);
    bad_uv     = wr_uv && !retry_ok(lreq_r.data);
    bad_oc     = wr_oc && !retry_ok(lreq_r.data);
    bad_trip   = wr_trip && ((wmant < alarm_r) || (wmant < OC_MIN)
                             || (wmant > OC_MAX));
    bad_alarm  = wr_alarm && (wmant > trip_r);
    cmd_invalid = bad_uv || bad_oc || bad_trip || bad_alarm;
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Reaction registers; rejected writes leave them untouched
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      uv_sd_r <= REACT_RST[`UVO_RSP_BIT];
      uv_rb_r <= REACT_RST[`UVO_RETRY_HI];
      oc_sd_r <= REACT_RST[`UVO_RSP_BIT];
      oc_rb_r <= REACT_RST[`UVO_RETRY_HI];
    end else if (do_restore) begin
      uv_sd_r <= nvm_rdata_i.uv_shutdown;
      uv_rb_r <= nvm_rdata_i.uv_retry_bit;
      oc_sd_r <= nvm_rdata_i.oc_shutdown;
      oc_rb_r <= nvm_rdata_i.oc_retry_bit;
    end else begin
      if (wr_uv && !bad_uv) begin
        uv_sd_r <= lreq_r.data[`UVO_RSP_BIT];
        uv_rb_r <= lreq_r.data[`UVO_RETRY_HI];
      end
      if (wr_oc && !bad_oc) begin
        oc_sd_r <= lreq_r.data[`UVO_RSP_BIT];
        oc_rb_r <= lreq_r.data[`UVO_RETRY_HI];
      end
    end
  end

  // Overcurrent trip and alarm limits
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      trip_r  <= OC_DEF;
      alarm_r <= OC_DEF - `UVO_WARN_OFFSET;
    end else if (do_restore) begin
      trip_r  <= nvm_rdata_i.oc_trip;
      alarm_r <= nvm_rdata_i.oc_trip - `UVO_WARN_OFFSET;
    end else begin
      if (wr_trip && !bad_trip) begin
        trip_r <= wmant;
      end
      if (wr_alarm && !bad_alarm) begin
        alarm_r <= wmant;
      end
    end
  end

  // Store image; only one retry bit per register is kept
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      nvm_store_o <= 1'b0;
      nvm_wdata_o <= '0;
    end else begin
      nvm_store_o <= do_store;
      if (do_store) begin
        nvm_wdata_o <= '{uv_sd_r, uv_rb_r, oc_sd_r, oc_rb_r, trip_r};
      end
    end
  end

  // Read answer, then acknowledge toggle one cycle later
  logic sack_pend_r;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      srd_data_r  <= 16'h0000;
      sack_pend_r <= 1'b0;
      sack_tog_r  <= 1'b0;
    end else begin
      sack_pend_r <= sreq_go;
      if (sack_pend_r) begin
        sack_tog_r <= ~sack_tog_r;
      end
      if (sreq_go) begin
        unique case (lreq_r.code)
          `UVO_CMD_UV_REACT: srd_data_r <= react_rd(uv_sd_r, uv_rb_r);
          `UVO_CMD_OC_REACT: srd_data_r <= react_rd(oc_sd_r, oc_rb_r);
          `UVO_CMD_OC_TRIP:  srd_data_r <= limit_rd(trip_r);
          `UVO_CMD_OC_ALARM: srd_data_r <= limit_rd(alarm_r);
          default:           srd_data_r <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Fault detection and status
  // ****************************************************************
  uvo_state_e  st_r;
  uvo_status_s stat_r, stat_set;
  logic        uv_evt, oc_evt, ocw_evt;

  // Undervoltage is only watched while regulating
  assign uv_evt  = uv_sync_r[1] && on_cmd_i && !ramping_i && power_en_o;
  assign oc_evt  = oc_sync_r[1] && power_en_o;
  assign ocw_evt = ocw_sync_r[1] && power_en_o;

  // Which flags each event raises
  always_comb begin
    stat_set = '0;
    stat_set.other_fault_flag        = uv_evt || ocw_evt;
    stat_set.voltage_summary_flag    = uv_evt;
    stat_set.undervoltage_fault_flag = uv_evt;
    stat_set.overcurrent_fault_byte  = oc_evt;
    stat_set.overcurrent_fault_flag  = oc_evt;
    stat_set.current_summary_flag    = oc_evt || ocw_evt;
    stat_set.overcurrent_warning_flag = ocw_evt;
    stat_set.comm_fault_flag         = cmd_invalid;
    stat_set.invalid_data_flag       = cmd_invalid;
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      stat_r <= '0;
    end else begin
      stat_r <= (do_clear ? uvo_status_s'('0) : stat_r) | stat_set;
    end
  end

  // Alert pin, active low; mask gates the analog faults only
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      smbalert_n_o <= 1'b1;
    end else begin
      smbalert_n_o <= !(stat_r.comm_fault_flag
                        || ((stat_r.other_fault_flag || stat_r.overcurrent_fault_byte)
                            && !alert_mask_i));
    end
  end

  assign status_o = stat_r;

  // ****************************************************************
  // Shutdown and retry sequencer
  // ****************************************************************
  logic        trip_sd, trip_latch;
  logic [31:0] hold_cnt_r;

  // Undervoltage uses its own and the overcurrent reaction
  always_comb begin
    trip_sd    = (oc_evt && oc_sd_r)
                 || (uv_evt && (uv_sd_r || oc_sd_r));
    trip_latch = oc_evt ? !oc_rb_r
                        : (!uv_rb_r || (oc_sd_r && !oc_rb_r));
  end

  // Run, hold off for seven rise times, or stay latched off
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r       <= UVO_ST_RUN;
      hold_cnt_r <= 32'h0;
    end else begin
      unique case (st_r)
        UVO_ST_RUN: begin
          hold_cnt_r <= 32'h0;
          if (trip_sd) begin
            st_r <= trip_latch ? UVO_ST_LATCH : UVO_ST_WAIT;
          end
        end
        UVO_ST_WAIT: begin
          hold_cnt_r <= hold_cnt_r + 32'h1;
          if (!on_cmd_i || hold_cnt_r == HOLD_LAST) begin
            st_r <= UVO_ST_RUN;
          end
        end
        UVO_ST_LATCH: begin
          if (do_clear || !on_cmd_i) begin
            st_r <= UVO_ST_RUN;
          end
        end
        default: st_r <= UVO_ST_RUN;
      endcase
    end
  end

  // Power stage enable; ignore mode drops it only on undervoltage while the overcurrent reaction is shutdown
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      power_en_o <= 1'b0;
    end else begin
      power_en_o <= (st_r == UVO_ST_RUN) && on_cmd_i && !trip_sd;
    end
  end

endmodule : uvo_fault_resp

// ---- uvo_fault_resp_assertions.sv ----
// Checker of the fault response block, bound to its ports.
// Assumes sys_rst_i also holds the link side of the block in reset.
`timescale 1ns/1ps

module uvo_fault_resp_chk
  import uvo_pkg::*;
(
  // Clocks and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        link_clk_i,
  // Link
  input  wire logic        cmd_valid_i,
  input  wire uvo_req_s    cmd_req_i,
  input  wire logic        cmd_busy_o,
  input  wire logic        rsp_valid_o,
  input  wire logic [15:0] rsp_data_o,
  // Sequencer and results
  input  wire logic        ramping_i,
  input  wire logic        power_en_o,
  input  wire uvo_status_s status_o,
  input  wire logic        smbalert_n_o
);
  // ********
  // Helpers
  // ********
  logic [7:0] code_r;

  // Code of the request in flight, so its answer can be judged
  always_ff @(posedge link_clk_i) begin
    if (cmd_valid_i && !cmd_busy_o) begin
      code_r <= cmd_req_i.code;
    end
  end

  // ********
  // Properties
  // ********
  property p_uv_flags;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(status_o.undervoltage_fault_flag) |->
      status_o.other_fault_flag && status_o.voltage_summary_flag;
  endproperty
  a_uv_flags: assert property (p_uv_flags) else $error("uv flags incomplete");

  property p_oc_flags;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(status_o.overcurrent_fault_flag) |->
      status_o.overcurrent_fault_byte && status_o.current_summary_flag;
  endproperty
  a_oc_flags: assert property (p_oc_flags) else $error("oc flags incomplete");

  property p_comm_flag;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(status_o.invalid_data_flag) |-> status_o.comm_fault_flag;
  endproperty
  a_comm_flag: assert property (p_comm_flag) else $error("comm flag missing");

  // Comm faults are never masked, so the alert must follow
  property p_comm_alert;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    status_o.comm_fault_flag |=> !smbalert_n_o;
  endproperty
  a_comm_alert: assert property (p_comm_alert) else $error("comm alert missing");

  property p_alert_cause;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !smbalert_n_o |-> $past(status_o) != '0;
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without flag");

  property p_uv_gate;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(status_o.undervoltage_fault_flag) |-> !$past(ramping_i) && $past(power_en_o);
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("uv flagged while ramping");

  property p_react_fmt;
    @(posedge link_clk_i) disable iff (sys_rst_i)
    rsp_valid_o && (code_r == 8'h45 || code_r == 8'h47) |->
      rsp_data_o[15:8] == 8'h00 && !rsp_data_o[6] && rsp_data_o[2:0] == 3'h7
      && rsp_data_o[5:3] inside {3'h0, 3'h7};
  endproperty
  a_react_fmt: assert property (p_react_fmt) else $error("reaction image bad");

  property p_limit_fmt;
    @(posedge link_clk_i) disable iff (sys_rst_i)
    rsp_valid_o && (code_r == 8'h46 || code_r == 8'h4A) |-> rsp_data_o[15:7] == 9'h1F0;
  endproperty
  a_limit_fmt: assert property (p_limit_fmt) else $error("limit image bad");

  c_reject: cover property (@(posedge sys_clk_i) $rose(status_o.invalid_data_flag));
  c_shut: cover property (@(posedge sys_clk_i) $fell(power_en_o));
  c_uv: cover property (@(posedge sys_clk_i) $rose(status_o.undervoltage_fault_flag));
endmodule : uvo_fault_resp_chk

bind uvo_fault_resp uvo_fault_resp_chk u_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
  .cmd_valid_i(cmd_valid_i), .cmd_req_i(cmd_req_i), .cmd_busy_o(cmd_busy_o),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .ramping_i(ramping_i),
  .power_en_o(power_en_o), .status_o(status_o), .smbalert_n_o(smbalert_n_o)
);

// ---- uvo_host_model.sv ----
// Link-side host model: one command at a time, each held until taken.
// Assumes the block takes a request on a link edge where busy is low.
`timescale 1ns/1ps

module uvo_host_model
  import uvo_pkg::*;
(
  // Link clock and answers
  input  wire logic link_clk_i,
  input  wire logic cmd_busy_i,
  input  wire logic rsp_valid_i,
  // Requests
  output logic      cmd_valid_o,
  output uvo_req_s  cmd_req_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_req_o   = '0;
  end

  // Released request lines show the inverse, so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge link_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_req_o   <= '{w, c, d};
    do @(posedge link_clk_i); while (cmd_busy_i !== 1'b0);
    cmd_valid_o <= 1'b0;
    cmd_req_o   <= ~cmd_req_o;
    // Bounded wait; a lost answer leaves its note queued in the bench
    while (rsp_valid_i !== 1'b1 && n < 12) begin
      @(posedge link_clk_i);
      n++;
    end
  endtask : xfer
endmodule : uvo_host_model

// ---- uvo_params.svh ----
// Constants of the undervoltage / overcurrent fault response block.
// Assumes inclusion by the package and by the block; definitions only.
`ifndef UVO_PARAMS_SVH
`define UVO_PARAMS_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define UVO_CMD_CLEAR_FAULTS   8'h03
`define UVO_CMD_STORE_ALL      8'h11
`define UVO_CMD_RESTORE_ALL    8'h12
`define UVO_CMD_UV_REACT       8'h45
`define UVO_CMD_OC_TRIP        8'h46
`define UVO_CMD_OC_REACT       8'h47
`define UVO_CMD_OC_ALARM       8'h4A

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define UVO_RSP_BIT            7
`define UVO_RETRY_HI           5
`define UVO_RETRY_LO           3
`define UVO_DELAY_CODE         3'h7
`define UVO_REACT_RESET        8'hBF
`define UVO_LIMIT_EXP          5'h1F
`define UVO_MANT_W             7

// Limits in 0.5 A counts; high-current variant then low-current variant
`define UVO_OC_MIN_HI          7'h0A
`define UVO_OC_MAX_HI          7'h50
`define UVO_OC_DEF_HI          7'h48
`define UVO_OC_MIN_LO          7'h0A
`define UVO_OC_MAX_LO          7'h48
`define UVO_OC_DEF_LO          7'h30
`define UVO_WARN_OFFSET        7'h04

// ****************************************************************
// Timing
// ****************************************************************
`define UVO_CLK_MHZ            200
`define UVO_RISE_TIME_US       1000
`define UVO_RETRY_RISES        7

`endif

// ---- uvo_pkg.sv ----
// Types shared by the fault response block and its surroundings.
// Assumes uvo_params.svh is on the include path.
`include "uvo_params.svh"

package uvo_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    UVO_ST_RUN   = 3'b001,
    UVO_ST_WAIT  = 3'b010,
    UVO_ST_LATCH = 3'b100
  } uvo_state_e;

  // One command from the link side
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } uvo_req_s;

  // Image kept in nonvolatile memory
  typedef struct packed {
    logic                     uv_shutdown;
    logic                     uv_retry_bit;
    logic                     oc_shutdown;
    logic                     oc_retry_bit;
    logic [`UVO_MANT_W-1:0]   oc_trip;
  } uvo_nvm_s;

  // Status bits seen by the host
  typedef struct packed {
    logic comm_fault_flag;
    logic other_fault_flag;
    logic overcurrent_fault_byte;
    logic voltage_summary_flag;
    logic current_summary_flag;
    logic undervoltage_fault_flag;
    logic overcurrent_fault_flag;
    logic overcurrent_warning_flag;
    logic invalid_data_flag;
  } uvo_status_s;

endpackage : uvo_pkg
